// File: logic/bls_pkg.sv
// boot loader sequencer: shared constants, types and the crc step.
// assumes a 10 MHz system clock and one serial nor flash on the pins.
package bls_pkg;
  // ---------------------------------------------------------------
  // warm-boot handoff
  // ---------------------------------------------------------------
  localparam logic [31:0] WDOG_MAGIC = 32'hB007C0D3;
  localparam logic [31:0] WDOG_XOR_KEY = 32'h4FF83F2D; // negated magic
  // ---------------------------------------------------------------
  // image and checksum
  // ---------------------------------------------------------------
  localparam logic [8:0] IMG_BYTES = 9'h100;
  localparam logic [7:0] PAYLOAD_BYTES = 8'hFC;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_XOROUT = 32'h00000000;
  localparam logic [7:0] ATTEMPTS = 8'h80;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_KHZ = 10000;
  localparam int ATTEMPT_TIME_MS = 4;
  localparam int ATTEMPT_CYCLES = ATTEMPT_TIME_MS * SYS_CLK_KHZ;
  localparam logic [1:0] PIN_SETTLE = 2'h3; // sync depth plus one
  localparam logic [3:0] HALF_MIN = 4'h3; // link cycles per sck half
  // ---------------------------------------------------------------
  // serial sequences
  // ---------------------------------------------------------------
  localparam logic [5:0] EXIT_LONG_CLKS = 6'h20;
  localparam logic [5:0] EXIT_SHORT_CLKS = 6'h10;
  localparam logic [5:0] CMD_BITS = 6'h20;
  localparam logic [5:0] DATA_LAST = 6'h27; // cmd bits plus 7
  localparam logic [7:0] READ_CMD = 8'h03;
  // ---------------------------------------------------------------
  // rom header offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] ROM_SP_OFS = 5'h00;
  localparam logic [4:0] ROM_RESET_OFS = 5'h04;
  localparam logic [4:0] ROM_NMI_OFS = 5'h08;
  localparam logic [4:0] ROM_FAULT_OFS = 5'h0C;
  localparam logic [4:0] ROM_MAGIC_OFS = 5'h10;
  localparam logic [4:0] ROM_FUNC_OFS = 5'h14;
  localparam logic [4:0] ROM_LOOKUP_OFS = 5'h18;
  localparam logic [2:0] LAUNCH_DONE = 3'h6; // six launch words
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {OP_EXIT1, OP_EXIT2, OP_EXIT3, OP_READ} bls_op_e;
  typedef enum logic [1:0] {J_WDOG, J_FLASH, J_CORE1} bls_jkind_e;
  typedef struct packed {
    logic valid; bls_jkind_e kind; logic [31:0] sp; logic [31:0] pc;
  } bls_jump_s;
  typedef struct packed {logic valid; logic [31:0] data;} bls_word_s;
  typedef struct packed {logic we; logic [7:0] addr; logic [7:0] data;}
    bls_sram_s;
  typedef struct packed {
    logic [31:0] s4; logic [31:0] s5; logic [31:0] s6; logic [31:0] s7;
  } bls_scratch_s;
  typedef struct packed {
    logic sck; logic sel_n; logic sel_oe_n; logic [3:0] io;
    logic [3:0] io_oe_n; logic pull_up; logic pull_dn;
  } bls_flash_s;
  // one crc32 step, msb first, no reflection
  function automatic logic [31:0] bls_crc_byte(input logic [31:0] c,
                                               input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[31] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : bls_crc_byte
endpackage : bls_pkg

// File: logic/bls_top.sv
// boot loader sequencer: core start, warm handoff, flash load, launch.
// assumes scratch, mailbox and rom port sit on clk_i; the flash pins
// are handled on link_clk_i, which the bench runs free.
//
// Overview of operation
// - both cores start together; core 1 sleeps
// - rescue power-up clears flag and halts
// - checks run rescue, handoff, pin, flash
// - handoff only on non power-on resets
// - handoff needs magic and xored entry match
// - handoff loads stack and entry from scratch
// - scratch word 4 zeroed before handoff
// - select pin tied low skips flash boot
// - exit step one: deselected, pulled low, 32 clocks
// - exit step two: selected, pulled high, 32 clocks
// - exit step three: mosi high, 16 clocks
// - read 256 bytes with 03h into sram
// - last four bytes: little-endian crc of 252
// - crc32 poly, all-ones init, no reflection
// - 128 timed attempts, varying speed, then usb
// - crc pass jumps to payload start
// - launch words echoed by second core
// - rom holds four vector words at fixed offsets
// - rom holds signature, version, three pointers
`timescale 1ns/100ps
module bls_top import bls_pkg::*; #(
  parameter int ATTEMPT_CYC = ATTEMPT_CYCLES, // shorten in simulation
  parameter logic [31:0] SRAM_BASE = 32'h20041000, // boot bank start
  parameter logic [31:0] ROM_SP = 32'h20042000,
  parameter logic [31:0] ROM_RESET = 32'h000000EB,
  parameter logic [31:0] ROM_NMI = 32'h00000035,
  parameter logic [31:0] ROM_FAULT = 32'h00000161,
  parameter logic [23:0] ROM_SIG = 24'h5A5A01, // arbitrary value
  parameter logic [7:0] ROM_VERSION = 8'h01, // arbitrary value
  parameter logic [15:0] ROM_FUNC_PTR = 16'h007A,
  parameter logic [15:0] ROM_DATA_PTR = 16'h00C4,
  parameter logic [15:0] ROM_LOOKUP_PTR = 16'h001D
) (
  input wire logic clk_i,
  input wire logic link_clk_i,
  input wire logic arst_n_i,
  input wire logic core_identity_i, // identity of this core
  input wire logic rescue_flag_i, // power-up came from rescue port
  input wire logic reset_was_por_i, // power-on or brown-out reset
  input wire bls_scratch_s scratch_i, // watchdog scratch 4..7
  output logic rescue_clr_o,
  output logic scr4_clr_o, // write zero to scratch 4
  output logic halt_o,
  output logic usb_boot_o,
  output logic deep_sleep_ctl_o,
  output logic wait_for_event_o,
  output bls_jump_s jump_o,
  output logic [31:0] vector_base_o,
  input wire bls_word_s mbox_rx_i,
  output logic mbox_rx_ready_o,
  output bls_word_s mbox_tx_o,
  input wire logic mbox_tx_ready_i,
  output bls_sram_s sram_o, // boot_sram_bank write port
  input wire logic [4:0] rom_addr_i,
  output logic [31:0] rom_rdata_o,
  output bls_flash_s flash_o,
  input wire logic flash_select_n_i,
  input wire logic [3:0] flash_io_i
);
  localparam int TW = $clog2(ATTEMPT_CYC + 1);
  localparam logic [TW-1:0] ATTEMPT_LAST = TW'(ATTEMPT_CYC - 1);

  // -----------------------------------------------------------------
  // system-side state
  // -----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_START = 4'h0, S_WD_CLR = 4'h1, S_PIN = 4'h3, S_CMD = 4'h2,
    S_WAIT = 4'h6, S_CHECK = 4'h7, S_RETRY = 4'h5, S_RUN = 4'h4,
    S_USB = 4'hC, S_HALT = 4'hD, S_JUMP = 4'h9, S_SLEEP = 4'h8,
    S_LISTEN = 4'hA, S_ECHO = 4'hB, S_LAUNCH = 4'hF
  } bls_st_e;

  typedef struct packed {
    bls_st_e st;
    logic sel_s1, sel_s2; // select pin sync
    logic done_s1, done_s2, done_seen; // link done event
    logic byte_s1, byte_s2, byte_seen; // link byte event
    logic cmd_tgl, ack_tgl; // events toward link
    bls_op_e op; // command word, stable while busy
    logic [1:0] div;
    logic [7:0] tries;
    logic [TW-1:0] timer;
    logic [1:0] settle;
    logic [8:0] idx; // image byte index
    logic [31:0] crc;
    logic [31:0] img_crc;
    bls_sram_s sram;
    bls_jump_s jump;
    logic [31:0] vbase;
    logic [31:0] sp_hold;
    logic [2:0] seq; // launch word position
    logic [31:0] echo;
    logic rescue_clr, scr4_clr, halt, usb, sleep;
    logic [31:0] rom;
  } bls_sys_s;

  bls_sys_s s_q, s_d;

  // -----------------------------------------------------------------
  // link-side state
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {L_IDLE = 2'h0, L_RUN = 2'h1, L_ACK = 2'h3}
    bls_lst_e;

  typedef struct packed {
    bls_lst_e st;
    logic cmd_s1, cmd_s2, cmd_seen;
    logic ack_s1, ack_s2, ack_seen;
    logic miso_s1, miso_s2;
    logic byte_tgl, done_tgl;
    bls_op_e op;
    logic [3:0] half; // link cycles per sck half
    logic [3:0] divcnt;
    logic sck, sel_n, sel_drv;
    logic [5:0] bitcnt;
    logic [7:0] bytecnt;
    logic [31:0] sh; // outgoing command bits
    logic [7:0] rx; // incoming byte
  } bls_link_s;

  bls_link_s l_q, l_d;

  // -----------------------------------------------------------------
  // rom header decode
  // -----------------------------------------------------------------
  // word-wide read; byte offsets 0x13/0x16 live inside their words
  function automatic logic [31:0] rom_word(input logic [4:0] a);
    logic [4:0] w;
    w = {a[4:2], 2'b00};
    unique case (w)
      ROM_SP_OFS: rom_word = ROM_SP;
      ROM_RESET_OFS: rom_word = ROM_RESET;
      ROM_NMI_OFS: rom_word = ROM_NMI;
      ROM_FAULT_OFS: rom_word = ROM_FAULT;
      ROM_MAGIC_OFS: rom_word = {ROM_VERSION, ROM_SIG[7:0],
                                 ROM_SIG[15:8], ROM_SIG[23:16]};
      ROM_FUNC_OFS: rom_word = {ROM_DATA_PTR, ROM_FUNC_PTR};
      ROM_LOOKUP_OFS: rom_word = {16'h0000, ROM_LOOKUP_PTR};
      default: rom_word = 32'h00000000;
    endcase
  endfunction : rom_word

  // -----------------------------------------------------------------
  // system sequencer
  // -----------------------------------------------------------------
  // warm handoff test; s5 must be entry xored with the key
  logic wd_ok;
  assign wd_ok = (scratch_i.s4 == WDOG_MAGIC) &&
                 (scratch_i.s5 == (scratch_i.s7 ^ WDOG_XOR_KEY));

  always_comb begin
    logic [7:0] b;
    s_d = s_q;
    b = l_q.rx; // stable until acknowledged
    // synchronisers from the link domain and the select pin
    s_d.sel_s1 = flash_select_n_i;
    s_d.sel_s2 = s_q.sel_s1;
    s_d.done_s1 = l_q.done_tgl;
    s_d.done_s2 = s_q.done_s1;
    s_d.byte_s1 = l_q.byte_tgl;
    s_d.byte_s2 = s_q.byte_s1;
    // single-cycle strobes default off
    s_d.sram.we = 1'b0;
    s_d.rescue_clr = 1'b0;
    s_d.scr4_clr = 1'b0;
    s_d.rom = rom_word(rom_addr_i);
    // attempt timer runs on the system clock
    s_d.timer = s_q.timer + TW'(1);
    unique case (s_q.st)
      S_START: begin
        if (core_identity_i) begin
          s_d.st = S_SLEEP;
          s_d.sleep = 1'b1;
        end else if (rescue_flag_i) begin
          s_d.rescue_clr = 1'b1;
          s_d.halt = 1'b1;
          s_d.st = S_HALT;
        end else if (!reset_was_por_i && wd_ok) begin
          s_d.scr4_clr = 1'b1;
          s_d.st = S_WD_CLR;
        end else begin
          s_d.settle = 2'h0;
          s_d.st = S_PIN;
        end
      end
      S_WD_CLR: begin
        // scratch 4 cleared one cycle ahead of the jump
        s_d.jump = '{1'b1, J_WDOG, scratch_i.s6, scratch_i.s7};
        s_d.st = S_JUMP;
      end
      S_PIN: begin
        // wait for the sync chain to carry the real pin level
        if (s_q.settle != PIN_SETTLE) begin
          s_d.settle = s_q.settle + 2'h1;
        end else if (!s_q.sel_s2) begin
          s_d.usb = 1'b1;
          s_d.st = S_USB;
        end else begin
          s_d.tries = 8'h00;
          s_d.timer = '0;
          s_d.div = 2'h0;
          s_d.op = OP_EXIT1;
          s_d.st = S_CMD;
        end
      end
      S_CMD: begin
        // a read restarts the image and checksum
        if (s_q.op == OP_READ) begin
          s_d.idx = 9'h000;
          s_d.crc = CRC_INIT;
          s_d.img_crc = 32'h00000000;
        end
        s_d.cmd_tgl = ~s_q.cmd_tgl;
        s_d.st = S_WAIT;
      end
      S_WAIT: begin
        if (s_q.byte_s2 != s_q.byte_seen) begin
          s_d.byte_seen = s_q.byte_s2;
          s_d.ack_tgl = ~s_q.ack_tgl;
          s_d.sram = '{1'b1, s_q.idx[7:0], b};
          s_d.idx = s_q.idx + 9'h001;
          if (s_q.idx[7:0] < PAYLOAD_BYTES) begin
            s_d.crc = bls_crc_byte(s_q.crc, b);
          end else begin
            // trailer bytes, least significant first
            s_d.img_crc[8*s_q.idx[1:0] +: 8] = b;
          end
        end
        if (s_q.done_s2 != s_q.done_seen) begin
          s_d.done_seen = s_q.done_s2;
          if (s_q.op == OP_READ) begin
            s_d.st = S_CHECK;
          end else begin
            s_d.op = bls_op_e'(s_q.op + 2'h1);
            s_d.st = S_CMD;
          end
        end
      end
      S_CHECK: begin
        // a short image never passes: all 256 bytes must arrive
        if (s_q.idx == IMG_BYTES &&
            (s_q.crc ^ CRC_XOROUT) == s_q.img_crc) begin
          s_d.jump = '{1'b1, J_FLASH, ROM_SP, SRAM_BASE};
          s_d.st = S_RUN;
        end else begin
          s_d.st = S_RETRY;
        end
      end
      S_RETRY: begin
        if (s_q.tries == ATTEMPTS - 8'h01) begin
          s_d.usb = 1'b1;
          s_d.st = S_USB;
        end else if (s_q.timer >= ATTEMPT_LAST) begin
          // next attempt at a different serial speed
          s_d.tries = s_q.tries + 8'h01;
          s_d.div = s_q.tries[1:0] + 2'h1;
          s_d.timer = '0;
          s_d.op = OP_EXIT1;
          s_d.st = S_CMD;
        end
      end
      S_SLEEP: begin
        // mailbox traffic wakes the second core
        if (mbox_rx_i.valid) begin
          s_d.sleep = 1'b0;
          s_d.seq = 3'h0;
          s_d.st = S_LISTEN;
        end
      end
      S_LISTEN: begin
        if (mbox_rx_i.valid) begin
          s_d.echo = mbox_rx_i.data;
          s_d.st = S_ECHO;
          if (mbox_rx_i.data == 32'h00000000) begin
            // a zero opens a fresh sequence unless it follows a zero
            s_d.seq = (s_q.seq == 3'h1 || s_q.seq == 3'h2) ? 3'h2 : 3'h1;
          end else begin
            unique case (s_q.seq)
              3'h2: s_d.seq = (mbox_rx_i.data == 32'h00000001) ?
                              3'h3 : 3'h0;
              3'h3: begin
                s_d.vbase = mbox_rx_i.data;
                s_d.seq = 3'h4;
              end
              3'h4: begin
                s_d.sp_hold = mbox_rx_i.data;
                s_d.seq = 3'h5;
              end
              3'h5: s_d.seq = LAUNCH_DONE;
              default: s_d.seq = 3'h0;
            endcase
          end
        end
      end
      S_ECHO: begin
        if (mbox_tx_ready_i) begin
          if (s_q.seq == LAUNCH_DONE) begin
            s_d.jump = '{1'b1, J_CORE1, s_q.sp_hold, s_q.echo};
            s_d.st = S_LAUNCH;
          end else begin
            s_d.st = S_LISTEN;
          end
        end
      end
      S_RUN, S_USB, S_HALT, S_JUMP, S_LAUNCH: begin
        s_d.timer = s_q.timer; // terminal, timer frozen
      end
      default: s_d.st = S_START;
    endcase
  end

  // system state register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
      s_q.st <= S_START;
      s_q.sel_s1 <= 1'b1;
      s_q.sel_s2 <= 1'b1;
      s_q.crc <= CRC_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------
  // link engine
  // -----------------------------------------------------------------
  always_comb begin
    logic [5:0] nclk;
    logic [7:0] rx_n;
    l_d = l_q;
    nclk = (l_q.op == OP_EXIT3) ? EXIT_SHORT_CLKS : EXIT_LONG_CLKS;
    rx_n = {l_q.rx[6:0], l_q.miso_s2};
    l_d.cmd_s1 = s_q.cmd_tgl;
    l_d.cmd_s2 = l_q.cmd_s1;
    l_d.ack_s1 = s_q.ack_tgl;
    l_d.ack_s2 = l_q.ack_s1;
    l_d.miso_s1 = flash_io_i[1];
    l_d.miso_s2 = l_q.miso_s1;
    unique case (l_q.st)
      L_IDLE: begin
        if (l_q.cmd_s2 != l_q.cmd_seen) begin
          // command word was set before its toggle, so it is stable
          l_d.cmd_seen = l_q.cmd_s2;
          l_d.op = s_q.op;
          l_d.half = HALF_MIN + {2'b00, s_q.div};
          l_d.divcnt = 4'h0;
          l_d.sck = 1'b0;
          l_d.bitcnt = 6'h00;
          l_d.bytecnt = 8'h00;
          l_d.sh = {READ_CMD, 24'h000000};
          l_d.sel_drv = 1'b1;
          l_d.sel_n = (s_q.op == OP_EXIT1);
          l_d.st = L_RUN;
        end
      end
      L_RUN: begin
        if (l_q.divcnt != l_q.half - 4'h1) begin
          l_d.divcnt = l_q.divcnt + 4'h1;
        end else begin
          l_d.divcnt = 4'h0;
          l_d.sck = ~l_q.sck;
          if (l_q.sck) begin
            // falling edge closes one clock
            l_d.bitcnt = l_q.bitcnt + 6'h01;
            if (l_q.op != OP_READ) begin
              if (l_q.bitcnt == nclk - 6'h01) begin
                l_d.sel_n = 1'b1;
                l_d.done_tgl = ~l_q.done_tgl;
                l_d.st = L_IDLE;
              end
            end else if (l_q.bitcnt < CMD_BITS) begin
              l_d.sh = {l_q.sh[30:0], 1'b0};
            end else begin
              l_d.rx = rx_n;
              if (l_q.bitcnt == DATA_LAST) begin
                // stall the clock until the byte is taken
                l_d.bitcnt = CMD_BITS;
                l_d.byte_tgl = ~l_q.byte_tgl;
                l_d.st = L_ACK;
              end
            end
          end
        end
      end
      L_ACK: begin
        if (l_q.ack_s2 != l_q.ack_seen) begin
          l_d.ack_seen = l_q.ack_s2;
          if (l_q.bytecnt == IMG_BYTES[7:0] - 8'h01) begin
            l_d.sel_n = 1'b1;
            l_d.done_tgl = ~l_q.done_tgl;
            l_d.st = L_IDLE;
          end else begin
            l_d.bytecnt = l_q.bytecnt + 8'h01;
            l_d.st = L_RUN;
          end
        end
      end
      default: l_d.st = L_IDLE;
    endcase
  end

  // link state register
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      l_q <= '0;
      l_q.st <= L_IDLE;
      l_q.sel_n <= 1'b1;
      l_q.half <= HALF_MIN;
    end else begin
      l_q <= l_d;
    end
  end

  // -----------------------------------------------------------------
  // pin drive; select stays undriven until first command so the
  // tied-low strap can be sensed
  // -----------------------------------------------------------------
  logic active, is_drv;
  assign active = (l_q.st != L_IDLE);
  assign is_drv = active && (l_q.op == OP_EXIT3 || l_q.op == OP_READ);

  always_comb begin
    flash_o.sck = l_q.sck;
    flash_o.sel_n = l_q.sel_n;
    flash_o.sel_oe_n = ~l_q.sel_drv;
    flash_o.pull_dn = active && (l_q.op == OP_EXIT1);
    flash_o.pull_up = active && (l_q.op == OP_EXIT2);
    // only mosi driven; the rest stay high impedance
    flash_o.io = {3'b000, (l_q.op == OP_READ) ? l_q.sh[31] : 1'b1};
    flash_o.io_oe_n = {3'b111, ~is_drv};
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign rescue_clr_o = s_q.rescue_clr;
  assign scr4_clr_o = s_q.scr4_clr;
  assign halt_o = s_q.halt;
  assign usb_boot_o = s_q.usb;
  assign deep_sleep_ctl_o = s_q.sleep;
  assign wait_for_event_o = s_q.sleep;
  assign jump_o = s_q.jump;
  assign vector_base_o = s_q.vbase;
  assign mbox_rx_ready_o = (s_q.st == S_LISTEN);
  assign mbox_tx_o = '{(s_q.st == S_ECHO), s_q.echo};
  assign sram_o = s_q.sram;
  assign rom_rdata_o = s_q.rom;
endmodule : bls_top

// File: verification/bls_flash_model.sv
// serial flash model: answers the plain read with a 256-byte image.
// assumes data launched after falling clocks, taken on rising ones.
`timescale 1ns/100ps
module bls_flash_model (
  input wire logic sck_i,
  input wire logic sel_n_i,
  input wire logic mosi_i,
  output logic drv_o, // driving the data-out line
  output logic miso_o
);
  logic [7:0] img [256]; // image, written by the bench
  logic [7:0] cmd = 8'h00; // instruction shifted in
  int n = 0; // falling clocks in this selection
  initial {drv_o, miso_o} = 2'b00;
  // instruction byte on the first eight rising clocks
  always @(posedge sck_i) if (n < 8) cmd = {cmd[6:0], mosi_i};
  // a released line shows the inverse, never a stale copy
  always @(negedge sck_i or posedge sel_n_i) begin
    if (sel_n_i) begin
      n = 0;
      drv_o = 1'b0;
      miso_o = ~miso_o;
    end else begin
      n = n + 1;
      drv_o = cmd == 8'h03 && n >= 32;
      if (drv_o) miso_o = img[((n - 32) / 8) % 256][7 - (n - 32) % 8];
    end
  end
endmodule : bls_flash_model

// File: verification/bls_top_monitor.sv
// checker for the sequencer ports: start checks and exit pins.
// assumes a bind into bls_top; straps stay steady through a boot.
`timescale 1ns/100ps
module bls_top_monitor import bls_pkg::*; #(
  parameter logic [31:0] SRAM_BASE = 32'h0,
  parameter logic [31:0] ROM_SP = 32'h0
) (
  input wire logic clk_i,
  input wire logic link_clk_i,
  input wire logic arst_n_i,
  input wire logic core_identity_i,
  input wire logic rescue_flag_i,
  input wire logic reset_was_por_i,
  input wire bls_scratch_s scratch_i,
  input wire logic rescue_clr_o,
  input wire logic scr4_clr_o,
  input wire logic halt_o,
  input wire logic usb_boot_o,
  input wire logic deep_sleep_ctl_o,
  input wire logic wait_for_event_o,
  input wire bls_jump_s jump_o,
  input wire bls_flash_s flash_o
);
  // ----------------------------------------
  // start edge marker and handoff match
  // ----------------------------------------
  logic st_q; // low until the start edge has passed
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) st_q <= 1'b0;
    else st_q <= 1'b1;
  end
  wire logic c0 = !st_q && !core_identity_i; // core 0 start edge
  wire logic wd = scratch_i.s4 == WDOG_MAGIC &&
    scratch_i.s5 == (scratch_i.s7 ^ WDOG_XOR_KEY);
  halt_rescue_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    c0 && rescue_flag_i |=> rescue_clr_o && halt_o) else $error("no halt");
  halt_alone_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    halt_o |-> !jump_o.valid && !usb_boot_o) else $error("halt not alone");
  wdog_jump_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    c0 && !rescue_flag_i && !reset_was_por_i && wd |=> scr4_clr_o ##1
    jump_o == {3'b100, scratch_i.s6, scratch_i.s7}) else $error("bad handoff");
  clear_cause_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    scr4_clr_o |-> !reset_was_por_i && !rescue_flag_i && wd) else $error("clr");
  flash_dest_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    jump_o.valid && jump_o.kind == J_FLASH |-> jump_o.pc == SRAM_BASE &&
    jump_o.sp == ROM_SP) else $error("flash jump target wrong");
  core_sleep_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !st_q && core_identity_i |=> deep_sleep_ctl_o && wait_for_event_o &&
    !halt_o) else $error("second core awake");
  exit_low_a: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
    flash_o.pull_dn |-> flash_o.sel_n && !flash_o.sel_oe_n &&
    flash_o.io_oe_n == 4'hF) else $error("exit step one pins wrong");
  exit_high_a: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
    flash_o.pull_up |-> !flash_o.sel_n && flash_o.io_oe_n == 4'hF)
    else $error("exit step two pins wrong");
  cover property (@(posedge clk_i) $rose(halt_o)); // main outcomes
  cover property (@(posedge clk_i) $rose(jump_o.valid) && jump_o.kind == J_FLASH);
  cover property (@(posedge clk_i) $rose(jump_o.valid) && jump_o.kind == J_CORE1);
endmodule : bls_top_monitor
bind bls_top bls_top_monitor #(.SRAM_BASE(SRAM_BASE), .ROM_SP(ROM_SP))
  u_mon (.*);

// File: verification/tb_top.sv
// bench: boots the sequencer under each strap set, feeds a flash image.
// assumes the flash model on the pins; link clock runs free.
`timescale 1ns/100ps
module tb_top import bls_pkg::*;;
  localparam int ACYC = 4000; // short slot, still above one load
  logic clk_i = 1'b0, link_clk_i = 1'b0, arst_n_i = 1'b0;
  logic core_identity_i = 1'b0, rescue_flag_i = 1'b0;
  logic reset_was_por_i = 1'b0, strap = 1'b1; // strap: undriven select
  logic mbox_tx_ready_i = 1'b1; // each echo refused once
  logic [4:0] rom_addr_i = 5'h00;
  bls_scratch_s scratch_i = '0;
  bls_word_s mbox_rx_i = '0, mbox_tx_o;
  logic rescue_clr_o, scr4_clr_o, halt_o, usb_boot_o, mbox_rx_ready_o;
  logic deep_sleep_ctl_o, wait_for_event_o, drv, miso;
  logic [31:0] vector_base_o, rom_rdata_o, sp_v, pc_v;
  bls_jump_s jump_o;
  bls_sram_s sram_o;
  bls_flash_s flash_o;
  logic [15:0] q [$]; // address and byte written into the boot bank
  int num_errors = 0, num_checks = 0;
  // pin levels: driven bits, else pulls, flash owns io1 when driving
  wire logic [3:0] pin = (flash_o.io & ~flash_o.io_oe_n) |
    ({4{flash_o.pull_up}} & flash_o.io_oe_n);
  wire logic [3:0] flash_io_i = drv ? {pin[3:2], miso, pin[0]} : pin;
  wire logic flash_select_n_i = flash_o.sel_oe_n ? strap : flash_o.sel_n;
  always #50 clk_i = ~clk_i;
  always #7.5 link_clk_i = ~link_clk_i;
  bls_top #(.ATTEMPT_CYC(ACYC)) dut (.*);
  bls_flash_model u_fl (.sck_i(flash_o.sck), .sel_n_i(flash_o.sel_n),
    .mosi_i(pin[0]), .drv_o(drv), .miso_o(miso));
  always @(negedge clk_i) if (sram_o.we === 1'b1) q.push_back(sram_o[15:0]);
  task automatic chk(string nm, logic [98:0] s, logic [98:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // reset with the given straps, settle past the pin check
  task automatic boot(logic i, r, p, s, logic [31:0] s5);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    {core_identity_i, rescue_flag_i, reset_was_por_i, strap} <= {i, r, p, s};
    scratch_i <= {WDOG_MAGIC, s5, sp_v, pc_v};
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (12) @(negedge clk_i);
  endtask : boot
  // one mailbox word, then its echo
  task automatic send(logic [31:0] w);
    int t = 0;
    if (w == 0) do @(negedge clk_i); while (mbox_tx_o.valid === 1'b1);
    @(posedge clk_i);
    mbox_rx_i <= {1'b1, w};
    do @(negedge clk_i); while (mbox_rx_ready_o !== 1'b1 && t++ < 50);
    @(posedge clk_i);
    mbox_rx_i <= '0;
    mbox_tx_ready_i <= 1'b0; // echo must stand while refused
    do @(negedge clk_i); while (mbox_tx_o.valid !== 1'b1 && t++ < 99);
    chk("echo", mbox_tx_o, {1'b1, w});
    @(posedge clk_i);
    mbox_tx_ready_i <= 1'b1;
  endtask : send
  function automatic logic [31:0] crc(int nb);
    logic [31:0] c = 32'hFFFFFFFF;
    for (int j = 0; j < nb * 8; j++)
      c = (c[31] ^ u_fl.img[j / 8][7 - j % 8]) ? (c << 1) ^ CRC_POLY : c << 1;
    return c;
  endfunction : crc
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    logic [3:0] tbl [4] = '{4'b1010, 4'b0010, 4'b0100, 4'b0001}; // r p s bad
    logic [31:0] s5, seq [9], rw [7];
    logic [4:0] ofs [7] = '{ROM_SP_OFS, ROM_RESET_OFS, ROM_NMI_OFS,
      ROM_FAULT_OFS, ROM_MAGIC_OFS, ROM_FUNC_OFS, ROM_LOOKUP_OFS};
    int e;
    void'($urandom(4));
    sp_v = $urandom();
    pc_v = $urandom() | 32'h1;
    // rescue, handoff, refused handoffs with the strap tied low
    foreach (tbl[k]) begin
      s5 = (pc_v ^ WDOG_XOR_KEY) ^ {32{tbl[k][0]}};
      boot(1'b0, tbl[k][3], tbl[k][2], tbl[k][1], s5);
      e = tbl[k][3] ? 1 : (!tbl[k][2] && !tbl[k][0]) ? 2 : 3;
      chk("halt", halt_o, e == 1);
      chk("usb", usb_boot_o, e == 3);
      chk("wdog", e == 2 ? jump_o : jump_o.valid,
        e == 2 ? {3'b100, sp_v, pc_v} : 67'h0);
    end
    // bad trailer first, repaired before the retry
    for (int j = 0; j < 252; j++) u_fl.img[j] = $urandom();
    {u_fl.img[255], u_fl.img[254], u_fl.img[253], u_fl.img[252]} = ~crc(252);
    boot(1'b0, 1'b0, 1'b1, 1'b1, 32'h0);
    for (e = 0; e < 9000 && q.size() < 256; e++) @(negedge clk_i);
    {u_fl.img[255], u_fl.img[254], u_fl.img[253], u_fl.img[252]} = crc(252);
    for (e = 0; e < 9000 && jump_o.valid !== 1'b1; e++) @(negedge clk_i);
    chk("retry", {usb_boot_o, q.size()}, 512);
    chk("flash", jump_o, {3'b101, dut.ROM_SP, dut.SRAM_BASE});
    for (int j = 0; j < 256; j++)
      chk("byte", q[256 + j], {j[7:0], u_fl.img[j]});
    // second core: a wrong word forces a restart
    seq = '{0, 0, 5, 0, 0, 1, $urandom(), sp_v, pc_v};
    boot(1'b1, 1'b0, 1'b0, 1'b1, 32'h0);
    chk("sleep", {deep_sleep_ctl_o, wait_for_event_o, halt_o}, 3'b110);
    foreach (seq[k]) send(seq[k]);
    repeat (2) @(negedge clk_i);
    chk("core1", {jump_o, vector_base_o}, {3'b110, sp_v, pc_v, seq[6]});
    // fixed header words, any byte inside each word
    rw = '{dut.ROM_SP, dut.ROM_RESET, dut.ROM_NMI, dut.ROM_FAULT,
      {dut.ROM_VERSION, dut.ROM_SIG[7:0], dut.ROM_SIG[15:8],
      dut.ROM_SIG[23:16]}, {dut.ROM_DATA_PTR, dut.ROM_FUNC_PTR},
      {16'h0000, dut.ROM_LOOKUP_PTR}};
    foreach (ofs[k]) begin
      @(posedge clk_i);
      rom_addr_i <= ofs[k] | 5'($urandom_range(3));
      @(posedge clk_i);
      @(negedge clk_i);
      chk("rom", rom_rdata_o, rw[k]);
    end
    tally_and_finish();
  end
endmodule : tb_top
